//--- rtl/fuel_mode_controller.sv
// Fuel mode selection, pump relay and injector gating for a two-injector throttle body.
// Assumes switch and fault pins are asynchronous; sensor words are sampled by the
// surrounding logic on clk and engine speed arrives as a number in rpm.
`timescale 1ns/1ps
`default_nettype none

module fuel_mode_controller #(
    parameter int unsigned PRIME_CYCLES    = fuel_mode_pkg::PRIME_CYCLES,
    parameter int unsigned REF_TIMEOUT_CYC = fuel_mode_pkg::REF_TIMEOUT_CYC,
    parameter logic [15:0] REV_LIMIT       = fuel_mode_pkg::REV_LIMIT_RST
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ignition_on,
    input  wire logic        crank_on,
    input  wire logic        ref_pulse,
    input  wire logic        fault_switch,
    input  wire logic [7:0]  throttle_position,
    input  wire logic [7:0]  coolant_temp_sensor,
    input  wire logic [7:0]  manifold_pressure,
    input  wire logic [15:0] engine_rpm,
    output var  logic        pump_relay,
    output var  logic        injector_a,
    output var  logic        injector_b,
    output var  logic [2:0]  mode,
    output var  logic        speed_reduce
);

    // Two-stage synchronisers for the pin inputs
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else begin
            sync_a <= {fault_switch, ref_pulse, crank_on, ignition_on};
            sync_b <= sync_a;
        end
    end
    logic ign, crank, ref_s, fault_s;
    assign {fault_s, ref_s, crank, ign} = sync_b;

    // Reference pulse edges and a watchdog saying the engine turns
    logic        ref_d;
    logic [31:0] ref_timer;
    logic        ref_alive;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ref_d     <= 1'b0;
            ref_timer <= 32'h0;
            ref_alive <= 1'b0;
        end else begin
            ref_d <= ref_s;
            if (ref_s && !ref_d) begin
                ref_timer <= REF_TIMEOUT_CYC;
                ref_alive <= 1'b1;
            end else if (ref_timer != 32'h0) begin
                ref_timer <= ref_timer - 32'h1;
            end else begin
                ref_alive <= 1'b0;
            end
        end
    end

    // Pump relay: prime timer on ignition rising, crank holds, dead engine drops
    logic        ign_d;
    logic [31:0] prime_cnt;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ign_d      <= 1'b0;
            prime_cnt  <= 32'h0;
            pump_relay <= 1'b0;
        end else begin
            ign_d <= ign;
            if (!ign)
                prime_cnt <= 32'h0;
            else if (!ign_d)
                prime_cnt <= PRIME_CYCLES;
            else if (prime_cnt != 32'h0)
                prime_cnt <= prime_cnt - 32'h1;
            // Crank wins even before the first reference edge so the pump can start
            pump_relay <= ign && (crank || prime_cnt != 32'h0 || ref_alive);
        end
    end

    // Overspeed latch with release only once speed is back under the limit
    logic overspeed;
    always_ff @(posedge clk) begin
        if (!rst_b)
            overspeed <= 1'b0;
        else if (engine_rpm > REV_LIMIT)
            overspeed <= 1'b1;
        else if (engine_rpm < REV_LIMIT)
            overspeed <= 1'b0;
    end

    // Fault switch edge latches speed reduction; single-injector hysteresis inside it
    logic fault_d;
    logic one_inj;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fault_d      <= 1'b0;
            speed_reduce <= 1'b0;
            one_inj      <= 1'b0;
        end else begin
            fault_d <= fault_s;
            if (fault_s != fault_d)
                speed_reduce <= 1'b1;
            if (!speed_reduce || engine_rpm < fuel_mode_pkg::REDUCE_LO_RPM)
                one_inj <= 1'b0;
            else if (engine_rpm > fuel_mode_pkg::REDUCE_HI_RPM)
                one_inj <= 1'b1;
        end
    end

    // Rapid rise detection on throttle and manifold pressure
    logic [7:0] tp_prev, map_prev;
    logic       accel;
    logic       fire;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tp_prev  <= 8'h00;
            map_prev <= 8'h00;
        end else if (fire) begin
            tp_prev  <= throttle_position;
            map_prev <= manifold_pressure;
        end
    end
    assign accel = (throttle_position > tp_prev && throttle_position - tp_prev >= fuel_mode_pkg::ACCEL_TP_STEP)
                || (manifold_pressure > map_prev
                    && manifold_pressure - map_prev >= fuel_mode_pkg::ACCEL_MAP_STEP);

    // Mode selection; cutoff is checked first so it overrides everything
    fuel_mode_pkg::fuel_mode_t cur, next_mode;
    logic full_tp;
    logic cutoff;
    assign full_tp = (throttle_position == fuel_mode_pkg::THROTTLE_FULL);
    assign cutoff  = !ign || !ref_alive || overspeed;
    always_comb begin
        next_mode = cur;
        // No exception while cranking: a dead distributor must never get fuel
        if (cutoff)
            next_mode = fuel_mode_pkg::MODE_CUTOFF;
        else if (engine_rpm <= fuel_mode_pkg::CRANK_RPM) begin
            if (full_tp && crank)
                next_mode = fuel_mode_pkg::MODE_FLOOD;
            else
                next_mode = fuel_mode_pkg::MODE_START;
        end else if (accel)
            next_mode = fuel_mode_pkg::MODE_ACCEL;
        else
            next_mode = fuel_mode_pkg::MODE_RUN;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur  <= fuel_mode_pkg::MODE_OFF;
            mode <= 3'b000;
        end else begin
            cur  <= next_mode;
            mode <= next_mode;
        end
    end

    // Pulse width per mode: colder coolant lengthens it, and higher pressure does too in run and accel
    logic [15:0] width;
    logic [7:0]  cold;
    assign cold = ~coolant_temp_sensor;
    always_comb begin
        case (cur)
            fuel_mode_pkg::MODE_START:
                width = fuel_mode_pkg::START_BASE_PW + {4'h0, cold[7:0], 4'h0}
                      - {8'h00, throttle_position[7:1], 1'b0};
            fuel_mode_pkg::MODE_RUN:
                width = fuel_mode_pkg::RUN_BASE_PW + {4'h0, cold[7:0], 4'h0}
                      + {4'h0, manifold_pressure, 4'h0};
            fuel_mode_pkg::MODE_ACCEL:
                width = fuel_mode_pkg::RUN_BASE_PW + {4'h0, cold[7:0], 4'h0}
                      + {4'h0, manifold_pressure, 4'h0}
                      + fuel_mode_pkg::ACCEL_EXTRA_PW;
            default:
                width = 16'h0000;
        endcase
    end

    // Fire on each reference edge when turning, on a short timer while cranking
    logic [15:0] start_tmr;
    always_ff @(posedge clk) begin
        if (!rst_b || cur != fuel_mode_pkg::MODE_START)
            start_tmr <= 16'h0;
        else if (start_tmr == fuel_mode_pkg::START_PERIOD)
            start_tmr <= 16'h0;
        else
            start_tmr <= start_tmr + 16'h1;
    end
    assign fire = (ref_s && !ref_d) || (start_tmr == fuel_mode_pkg::START_PERIOD);

    logic inhibit_all;
    assign inhibit_all = cur == fuel_mode_pkg::MODE_CUTOFF || cur == fuel_mode_pkg::MODE_FLOOD
                      || cur == fuel_mode_pkg::MODE_OFF || !ign;

    logic drv_a, drv_b;
    injector_pulse_gen #(.W(16)) u_inj_a (
        .clk     (clk),
        .rst_b   (rst_b),
        .fire    (fire),
        .width   (width),
        .inhibit (inhibit_all),
        .drive   (drv_a)
    );
    injector_pulse_gen #(.W(16)) u_inj_b (
        .clk     (clk),
        .rst_b   (rst_b),
        .fire    (fire),
        .width   (width),
        .inhibit (inhibit_all || one_inj),
        .drive   (drv_b)
    );

    // Register the drivers so the pins come from flip-flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            injector_a <= 1'b0;
            injector_b <= 1'b0;
        end else begin
            injector_a <= drv_a && !inhibit_all;
            injector_b <= drv_b && !inhibit_all && !one_inj;
        end
    end

    a_no_fuel_ign_off: assert property (@(posedge clk) disable iff (!rst_b)
        !ign |-> ##2 (!injector_a && !injector_b))
        else $error("injector fired with ignition off");
    a_flood_no_fuel: assert property (@(posedge clk) disable iff (!rst_b)
        cur == fuel_mode_pkg::MODE_FLOOD |-> ##1 (!injector_a && !injector_b))
        else $error("injector fired in clear flood");
    a_crank_pump_on: assert property (@(posedge clk) disable iff (!rst_b)
        (ign && crank) |=> pump_relay)
        else $error("pump off while cranking");
    a_pump_dead_off: assert property (@(posedge clk) disable iff (!rst_b)
        (!crank && !ref_alive && prime_cnt == 32'h0) |=> !pump_relay)
        else $error("pump on with no reference");
    a_prime_start: assert property (@(posedge clk) disable iff (!rst_b)
        (ign && !ign_d) |=> (prime_cnt == PRIME_CYCLES) ##1 pump_relay)
        else $error("prime not started");
    a_one_injector: assert property (@(posedge clk) disable iff (!rst_b)
        one_inj |=> !injector_b)
        else $error("second injector fired in reduction");
    a_overspeed_cut: assert property (@(posedge clk) disable iff (!rst_b)
        overspeed |=> (cur == fuel_mode_pkg::MODE_CUTOFF))
        else $error("overspeed not cut");
    a_fault_edge: assert property (@(posedge clk) disable iff (!rst_b)
        (fault_s != fault_d) |=> speed_reduce)
        else $error("fault edge missed");

endmodule // fuel_mode_controller

`default_nettype wire

//--- pkg/fuel_mode_pkg.sv
// Constants used by the fuel mode controller alone; its injector pulse generator uses none of them.
// Assumes a 10 MHz system clock.
`default_nettype none

package fuel_mode_pkg;

    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned PRIME_TIME_MS   = 2000;
    localparam int unsigned PRIME_CYCLES    = (CLK_HZ / 1000) * PRIME_TIME_MS;
    localparam int unsigned REF_TIMEOUT_MS  = 500;
    localparam int unsigned REF_TIMEOUT_CYC = (CLK_HZ / 1000) * REF_TIMEOUT_MS;

    localparam logic [15:0] CRANK_RPM       = 16'h012c;  // 300
    localparam logic [15:0] REDUCE_HI_RPM   = 16'h07d0;  // 2000
    localparam logic [15:0] REDUCE_LO_RPM   = 16'h04b0;  // 1200
    localparam logic [15:0] REV_LIMIT_RST   = 16'h1388;  // 5000

    localparam logic [7:0]  THROTTLE_FULL   = 8'hff;
    localparam logic [7:0]  ACCEL_TP_STEP   = 8'h10;
    localparam logic [7:0]  ACCEL_MAP_STEP  = 8'h10;

    localparam logic [15:0] START_BASE_PW   = 16'h0100;
    localparam logic [15:0] RUN_BASE_PW     = 16'h0400;
    localparam logic [15:0] ACCEL_EXTRA_PW  = 16'h0800;
    localparam logic [15:0] START_PERIOD    = 16'h1000;

    typedef enum logic [2:0] {
        MODE_OFF    = 3'b000,
        MODE_START  = 3'b001,
        MODE_FLOOD  = 3'b010,
        MODE_RUN    = 3'b011,
        MODE_ACCEL  = 3'b100,
        MODE_CUTOFF = 3'b101
    } fuel_mode_t;

endpackage

`default_nettype wire

//--- rtl/injector_pulse_gen.sv
// Injector pulse generator: one pulse per request, width from the mode logic.
// Assumes requests come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module injector_pulse_gen #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         fire,
    input  wire logic [W-1:0] width,
    input  wire logic         inhibit,
    output var  logic         drive
);

    logic [W-1:0] remain;

    // Count down the pulse; inhibit kills it at once so cutoff is immediate
    always_ff @(posedge clk) begin
        if (!rst_b || inhibit) begin
            remain <= '0;
            drive  <= 1'b0;
        end else if (fire && width != '0) begin
            remain <= width - 1'b1;
            drive  <= 1'b1;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end else begin
            drive  <= 1'b0;
        end
    end

endmodule // injector_pulse_gen

`default_nettype wire

//--- test/engine_model.sv
// Engine side model: makes ignition reference pulses while the engine turns.
// Assumes the bench starts and stops the engine with spin; pins change just after clk rises.
`timescale 1ns/1ps
`default_nettype none

module engine_model #(
    parameter int unsigned PERIOD = 1000
) (
    input  wire logic clk,
    input  wire logic spin,
    output var  logic ref_pulse
);
    int unsigned phase = 0;

    // Two-cycle pulse per reference event, so the synchroniser never misses one
    always @(posedge clk) begin
        phase <= (phase >= PERIOD - 1) ? 0 : phase + 1;
        ref_pulse <= #1 spin && (phase < 2);
    end
endmodule // engine_model

`default_nettype wire

//--- test/fuel_mode_controller_tb.sv
// Self-checking bench for the fuel mode controller, driving switches, sensor words and
// an engine model. Assumes shortened prime and reference timeout parameters.
`timescale 1ns/1ps
`default_nettype none

module fuel_mode_controller_tb;
    localparam int unsigned PRIME  = 50;
    localparam int unsigned REF_TO = 5000;
    // Reference period must exceed the longest run pulse, or pulses merge
    localparam int unsigned ENG_P  = 4000;

    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ignition_on = 1'b0;
    logic        crank_on = 1'b0;
    logic        fault_switch = 1'b0;
    logic        spin = 1'b0;
    logic        ref_pulse;
    logic [7:0]  tp = 8'h20;
    logic [7:0]  cool = 8'hc0;
    logic [7:0]  map = 8'h40;
    logic [15:0] rpm = 16'h0000;
    logic        pump_relay;
    logic        injector_a;
    logic        injector_b;
    logic [2:0]  mode;
    logic        speed_reduce;
    int          n_mismatch = 0;
    int          checks = 0;
    int          ca, cb, lo, hi;

    always #50 clk = ~clk;

    engine_model #(.PERIOD(ENG_P)) engine_model_inst (.clk(clk), .spin(spin), .ref_pulse(ref_pulse));

    fuel_mode_controller #(.PRIME_CYCLES(PRIME), .REF_TIMEOUT_CYC(REF_TO)) fuel_mode_controller_inst (
        .clk(clk), .rst_b(rst_b), .ignition_on(ignition_on), .crank_on(crank_on),
        .ref_pulse(ref_pulse), .fault_switch(fault_switch), .throttle_position(tp),
        .coolant_temp_sensor(cool), .manifold_pressure(map), .engine_rpm(rpm),
        .pump_relay(pump_relay), .injector_a(injector_a), .injector_b(injector_b),
        .mode(mode), .speed_reduce(speed_reduce));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Open time of each injector over a window, a proxy for fuel delivered
    task automatic open_time(input int n, output int a, output int b);
        a = 0;
        b = 0;
        repeat (n) begin
            tick(1);
            a += (injector_a === 1'b1);
            b += (injector_b === 1'b1);
        end
    endtask

    task automatic t_prime();
        ignition_on = 1'b1;
        tick(10);
        check("prime pump", pump_relay, 1'b1);
        tick(PRIME);
        check("prime drop", pump_relay, 1'b0);
        ignition_on = 1'b0;
        tick(5);
        $display("test prime done");
    endtask

    task automatic t_flood();
        ignition_on = 1'b1;
        crank_on = 1'b1;
        tp = 8'hff;
        rpm = 16'd100;
        // The engine turns while cranking; fuel waits for the first reference edge
        spin = 1'b1;
        tick(ENG_P + 20);
        check("crank pump", pump_relay, 1'b1);
        check("flood mode", mode, 3'd2);
        open_time(5000, ca, cb);
        check("flood fuel", ca + cb, 0);
        tp = 8'hfe;
        tick(5);
        check("start mode", mode, 3'd1);
        open_time(5000, ca, cb);
        check("start fuel", ca > 0, 1'b1);
        $display("test flood done");
    endtask

    task automatic t_run();
        logic seen4;
        spin = 1'b1;
        rpm = 16'd1000;
        crank_on = 1'b0;
        map = 8'h10;
        cool = 8'hf0;
        tick(2 * ENG_P);
        check("run mode", mode, 3'd3);
        check("run pump", pump_relay, 1'b1);
        // One window of a whole period holds exactly one pulse width
        open_time(ENG_P, lo, cb);
        map = 8'h40;
        // Two periods: the first fire after a pressure rise is an acceleration pulse
        tick(2 * ENG_P);
        open_time(ENG_P, hi, cb);
        check("load richer", hi > lo, 1'b1);
        cool = 8'hc0;
        tick(ENG_P);
        open_time(ENG_P, lo, cb);
        check("cold richer", lo > hi, 1'b1);
        // A throttle drop with a sudden pressure rise should show as acceleration fuelling
        seen4 = 1'b0;
        tp = 8'ha0;
        map = 8'hff;
        repeat (3000) begin
            tick(1);
            seen4 |= (mode === 3'd4);
        end
        check("accel seen", seen4, 1'b1);
        $display("test run done");
    endtask

    task automatic t_cutoff();
        rpm = 16'd6000;
        tick(10);
        check("overspeed mode", mode, 3'd5);
        open_time(3000, ca, cb);
        check("overspeed fuel", ca + cb, 0);
        rpm = 16'd4000;
        tick(3000);
        check("overspeed end", mode, 3'd3);
        spin = 1'b0;
        tick(REF_TO + 100);
        check("no ref pump", pump_relay, 1'b0);
        open_time(3000, ca, cb);
        check("no ref fuel", ca + cb, 0);
        spin = 1'b1;
        tick(3000);
        ignition_on = 1'b0;
        tick(10);
        open_time(3000, ca, cb);
        check("key off fuel", ca + cb, 0);
        $display("test cutoff done");
    endtask

    // Runs last: speed reduction latches until reset
    task automatic t_reduce();
        ignition_on = 1'b1;
        rpm = 16'd1000;
        tick(3000);
        fault_switch = ~fault_switch;
        tick(10);
        check("reduce latch", speed_reduce, 1'b1);
        rpm = 16'd2500;
        tick(3000);
        open_time(4000, ca, cb);
        check("single inj a", ca > 0, 1'b1);
        check("single inj b", cb, 0);
        rpm = 16'd1100;
        tick(3000);
        open_time(4000, ca, cb);
        check("both again", cb > 0, 1'b1);
        $display("test reduce done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Tests need about 86k cycles; stop at 95k to keep the run bounded
    initial begin
        #9_500_000;
        n_mismatch++;
        test_done();
    end

    initial begin
        tick(8);
        rst_b = 1'b1;
        tick(2);
        t_prime();
        t_flood();
        t_run();
        t_cutoff();
        t_reduce();
        test_done();
    end
endmodule // fuel_mode_controller_tb

`default_nettype wire
